// [hw/pls_pkg.sv]
// Constants, config carrier and the reusable event divider of the synthesizer core

// ----------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------
package pls_pkg;
  localparam int        SHIFT_W    = 19;
  localparam int        REF_W      = 14;
  localparam int        MAIN_W     = 11;
  localparam int        SWAL_W     = 7;
  localparam int        PRE_W      = 8;
  localparam int        BITS_W     = 5;
  localparam logic [4:0] BITS_FULL = 5'h13;
  // Word field positions
  localparam int        CTRL_POS   = 0;
  localparam int        REF_LSB    = 1;
  localparam int        REF_MSB    = 14;
  localparam int        PSEL_POS   = 15;
  localparam int        SWAL_LSB   = 1;
  localparam int        SWAL_MSB   = 7;
  localparam int        MAIN_LSB   = 8;
  localparam int        MAIN_MSB   = 18;
  // Reset values of the latches
  localparam logic        PSEL_RST = 1'h0;
  localparam logic [13:0] REF_RST  = 14'h0003;
  localparam logic [10:0] MAIN_RST = 11'h003;
  localparam logic [6:0]  SWAL_RST = 7'h00;
  // Prescaler moduli, standard and high-band variants
  localparam logic [7:0] MOD_BIG_STD   = 8'h80;
  localparam logic [7:0] MOD_SMALL_STD = 8'h40;
  localparam logic [7:0] MOD_BIG_HB    = 8'h40;
  localparam logic [7:0] MOD_SMALL_HB  = 8'h20;
  // Synchroniser lanes
  localparam int SYN_DATA = 0;
  localparam int SYN_SCLK = 1;
  localparam int SYN_LOAD = 2;
  localparam int SYN_POL  = 3;
  localparam int SYN_REF  = 4;
  localparam int SYN_VCO  = 5;
  localparam int SYN_N    = 6;

  typedef struct packed {
    logic        presc_sel;
    logic [13:0] ref_ratio;
    logic [10:0] main_ratio;
    logic [6:0]  swallow;
  } pls_cfg_type;

  localparam pls_cfg_type CFG_RST = pls_cfg_type'({PSEL_RST, REF_RST, MAIN_RST, SWAL_RST});
endpackage : pls_pkg

// ----------------------------------------------------------------------------
// Event divider: one terminal pulse every ratio_i events
// ----------------------------------------------------------------------------
module pls_counter #(
  parameter int W = 8
) (
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic         evt_i,
  input  wire logic [W-1:0] ratio_i,
  output logic              tc_o
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         tc_nxt;

  // Count events, wrap at ratio minus one
  always_comb begin
    cnt_nxt = cnt_r;
    tc_nxt  = 1'b0;
    if (evt_i) begin
      if (cnt_r >= W'(ratio_i - W'(1))) begin
        cnt_nxt = '0;
        tc_nxt  = 1'b1;
      end else begin
        cnt_nxt = W'(cnt_r + W'(1));
      end
    end
  end

  // Register state
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
      tc_o  <= 1'b0;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
      tc_o  <= tc_nxt;
    end
  end
endmodule : pls_counter

// [hw/pls_synth_core.sv]
// Serial programming, dividers, phase detector and monitor of the synthesizer core
module pls_synth_core
  import pls_pkg::*;
#(
  parameter logic HIGH_BAND = 1'b0
) (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic ser_data_i,
  input  wire logic ser_clk_i,
  input  wire logic load_strobe_i,
  input  wire logic polarity_select_i,
  input  wire logic ref_clk_i,
  input  wire logic vco_clk_i,
  output logic      pump_up_o,
  output logic      pump_dn_o,
  output logic      monitor_o
);
  import pls_pkg::*;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [SYN_N-1:0] pin_w;
  logic [SYN_N-1:0] meta_r;
  logic [SYN_N-1:0] sync_r;
  logic [SYN_N-1:0] prev_r;
  logic [SYN_N-1:0] rise_w;

  // Gather pins into lanes
  assign pin_w = {vco_clk_i, ref_clk_i, polarity_select_i, load_strobe_i, ser_clk_i, ser_data_i};
  assign rise_w = sync_r & ~prev_r;

  // Two flops per lane, then one for edge finding
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else if (ce_i) begin
      meta_r <= pin_w;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // --------------------------------------------------------------------------
  // Serial shifter and latches
  // --------------------------------------------------------------------------
  logic [SHIFT_W-1:0] shift_r;
  logic [SHIFT_W-1:0] shift_nxt;
  logic [BITS_W-1:0]  bits_r;
  logic [BITS_W-1:0]  bits_nxt;
  pls_cfg_type        cfg_r;
  pls_cfg_type        cfg_nxt;

  // Shift on clock rise, transfer on strobe rise
  always_comb begin
    shift_nxt = shift_r;
    bits_nxt  = bits_r;
    cfg_nxt   = cfg_r;
    if (rise_w[SYN_SCLK]) begin
      shift_nxt = {shift_r[SHIFT_W-2:0], sync_r[SYN_DATA]};
      if (bits_r != BITS_FULL) begin
        bits_nxt = BITS_W'(bits_r + 5'h01);
      end
    end
    if (rise_w[SYN_LOAD]) begin
      bits_nxt = '0; // Short word is discarded
      if (bits_r == BITS_FULL) begin
        if (shift_r[CTRL_POS]) begin
          cfg_nxt.ref_ratio = shift_r[REF_MSB:REF_LSB];
          cfg_nxt.presc_sel = shift_r[PSEL_POS];
        end else begin
          cfg_nxt.swallow    = shift_r[SWAL_MSB:SWAL_LSB];
          cfg_nxt.main_ratio = shift_r[MAIN_MSB:MAIN_LSB];
        end
      end
    end
  end

  // Register shifter state
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      shift_r <= '0;
      bits_r  <= '0;
      cfg_r   <= CFG_RST;
    end else if (ce_i) begin
      shift_r <= shift_nxt;
      bits_r  <= bits_nxt;
      cfg_r   <= cfg_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Reference and RF dividers
  // --------------------------------------------------------------------------
  logic             ref_tc;
  logic             presc_tc;
  logic             main_tc;
  logic [PRE_W-1:0] mod_w;
  logic [PRE_W-1:0] presc_load;
  logic [SWAL_W-1:0] swal_left_r;
  logic [SWAL_W-1:0] swal_left_nxt;

  // Modulus pair from select bit and variant
  always_comb begin
    if (!cfg_r.presc_sel) begin
      mod_w = HIGH_BAND ? MOD_BIG_HB : MOD_BIG_STD;
    end else begin
      mod_w = HIGH_BAND ? MOD_SMALL_HB : MOD_SMALL_STD;
    end
    presc_load = (swal_left_r != '0) ? PRE_W'(mod_w + 8'h01) : mod_w;
  end

  // Reference divider
  pls_counter #(.W(REF_W)) u_ref_div (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .evt_i     (rise_w[SYN_REF]),
    .ratio_i   (cfg_r.ref_ratio),
    .tc_o      (ref_tc)
  );

  // Dual-modulus prescaler
  pls_counter #(.W(PRE_W)) u_presc (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .evt_i     (rise_w[SYN_VCO]),
    .ratio_i   (presc_load),
    .tc_o      (presc_tc)
  );

  // Main programmable counter
  pls_counter #(.W(MAIN_W)) u_main (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .evt_i     (presc_tc),
    .ratio_i   (cfg_r.main_ratio),
    .tc_o      (main_tc)
  );

  // Swallow count: reload per main cycle, spend one per prescaler cycle
  always_comb begin
    swal_left_nxt = swal_left_r;
    if (main_tc) begin
      swal_left_nxt = cfg_r.swallow;
    end else if (presc_tc && swal_left_r != '0) begin
      swal_left_nxt = SWAL_W'(swal_left_r - 7'h01);
    end
  end

  // Register swallow state
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      swal_left_r <= SWAL_RST;
    end else if (ce_i) begin
      swal_left_r <= swal_left_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Phase detector, pump outputs and monitor
  // --------------------------------------------------------------------------
  logic up_r;
  logic up_nxt;
  logic dn_r;
  logic dn_nxt;
  logic pump_up_nxt;
  logic pump_dn_nxt;
  logic monitor_nxt;

  // Frequency-phase detector; both high clears, new edge wins over clear
  always_comb begin
    if (up_r && dn_r) begin
      up_nxt = ref_tc;
      dn_nxt = main_tc;
    end else begin
      up_nxt = up_r | ref_tc;
      dn_nxt = dn_r | main_tc;
    end
    pump_up_nxt = sync_r[SYN_POL] ? up_r : dn_r;
    pump_dn_nxt = sync_r[SYN_POL] ? dn_r : up_r;
    monitor_nxt = sync_r[SYN_POL] ? ref_tc : main_tc;
  end

  // Register detector and outputs
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      up_r      <= 1'b0;
      dn_r      <= 1'b0;
      pump_up_o <= 1'b0;
      pump_dn_o <= 1'b0;
      monitor_o <= 1'b0;
    end else if (ce_i) begin
      up_r      <= up_nxt;
      dn_r      <= dn_nxt;
      pump_up_o <= pump_up_nxt;
      pump_dn_o <= pump_dn_nxt;
      monitor_o <= monitor_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb_sys @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  logic [REF_W-1:0]  ref_seen_r;
  logic [MAIN_W-1:0] main_seen_r;
  logic              ref_moved_r;
  logic              main_moved_r;

  // Helper counts of divider input events since the last terminal pulse
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      ref_seen_r   <= '0;
      main_seen_r  <= '0;
      ref_moved_r  <= 1'b0;
      main_moved_r <= 1'b0;
    end else if (ce_i) begin
      // A ratio change spoils the period in flight; set wins over clear
      ref_moved_r  <= (cfg_nxt.ref_ratio != cfg_r.ref_ratio) || (ref_moved_r && !ref_tc);
      main_moved_r <= (cfg_nxt.main_ratio != cfg_r.main_ratio) || (main_moved_r && !main_tc);
      if (ref_tc) begin
        ref_seen_r <= REF_W'(rise_w[SYN_REF]);
      end else if (rise_w[SYN_REF]) begin
        ref_seen_r <= REF_W'(ref_seen_r + 14'h0001);
      end
      if (main_tc) begin
        main_seen_r <= MAIN_W'(presc_tc);
      end else if (presc_tc) begin
        main_seen_r <= MAIN_W'(main_seen_r + 11'h001);
      end
    end
  end

  chk_shift_capture: assert property (
    ce_i && rise_w[SYN_SCLK] |=> shift_r == {$past(shift_r[SHIFT_W-2:0]), $past(sync_r[SYN_DATA])})
    else $error("shifter did not take the data bit");
  chk_ref_load: assert property (
    ce_i && rise_w[SYN_LOAD] && bits_r == BITS_FULL && shift_r[CTRL_POS]
    |=> cfg_r.ref_ratio == $past(shift_r[REF_MSB:REF_LSB]) && cfg_r.presc_sel == $past(shift_r[PSEL_POS])
        && $stable(cfg_r.main_ratio))
    else $error("reference word not latched");
  chk_main_load: assert property (
    ce_i && rise_w[SYN_LOAD] && bits_r == BITS_FULL && !shift_r[CTRL_POS]
    |=> cfg_r.main_ratio == $past(shift_r[MAIN_MSB:MAIN_LSB])
        && cfg_r.swallow == $past(shift_r[SWAL_MSB:SWAL_LSB]) && $stable(cfg_r.ref_ratio))
    else $error("main word not latched");
  chk_short_word: assert property (
    ce_i && rise_w[SYN_LOAD] && bits_r != BITS_FULL |=> $stable(cfg_r) && bits_r == '0)
    else $error("short word changed the latches");
  chk_ref_ratio: assert property (
    ref_tc && !ref_moved_r |-> ref_seen_r == cfg_r.ref_ratio)
    else $error("reference divider period wrong");
  chk_main_ratio: assert property (
    main_tc && !main_moved_r |-> main_seen_r == cfg_r.main_ratio)
    else $error("main counter period wrong");
  chk_modulus_sel: assert property (
    swal_left_r == '0 |-> presc_load == (cfg_r.presc_sel ? (HIGH_BAND ? 8'h20 : 8'h40)
                                                          : (HIGH_BAND ? 8'h40 : 8'h80)))
    else $error("prescaler modulus wrong");
  chk_swallow_reload: assert property (
    ce_i && main_tc |=> swal_left_r == $past(cfg_r.swallow))
    else $error("swallow count not reloaded");
  chk_pfd_reset: assert property (
    ce_i && up_r && dn_r |=> up_r == $past(ref_tc) && dn_r == $past(main_tc))
    else $error("detector did not clear after overlap");
  chk_pump_sense: assert property (
    ce_i && up_r && !dn_r
    |=> ($past(sync_r[SYN_POL]) ? (pump_up_o && !pump_dn_o) : (pump_dn_o && !pump_up_o)))
    else $error("pump direction wrong");
  chk_monitor_src: assert property (
    ce_i && ref_tc && !main_tc |=> monitor_o == $past(sync_r[SYN_POL]))
    else $error("monitor source wrong");

  cov_ref_load: cover property (rise_w[SYN_LOAD] && bits_r == BITS_FULL && shift_r[CTRL_POS]);
  cov_main_load: cover property (rise_w[SYN_LOAD] && bits_r == BITS_FULL && !shift_r[CTRL_POS]);
  cov_locked_pulse: cover property (up_r && dn_r);
  cov_swallow_run: cover property (presc_tc && swal_left_r != '0);
endmodule : pls_synth_core

// [bench/pls_host_model.sv]
// Host controller model driving the three-wire serial programming port
module pls_host_model (
  input  wire logic clk_sys_i,
  output logic      ser_data_o,
  output logic      ser_clk_o,
  output logic      load_strobe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins start low, serial clock stands still outside frames
  initial begin
    ser_data_o    = 1'b0;
    ser_clk_o     = 1'b0;
    load_strobe_o = 1'b0;
  end

  // Wait a number of system clock cycles
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : hold

  // Word builders; the caller keeps ratios at 3 or more and swallow not above main
  function automatic logic [18:0] ref_word(input logic [13:0] r, input logic psel);
    return {3'h0, psel, r, 1'b1};
  endfunction : ref_word

  function automatic logic [18:0] main_word(input logic [10:0] b, input logic [6:0] a);
    return {b, a, 1'b0};
  endfunction : main_word

  // Shift the low nbits MSB first at 400 ns a bit, then pulse the strobe
  task automatic send_word(input logic [18:0] word, input int nbits);
    for (int i = nbits - 1; i >= 0; i--) begin
      ser_data_o <= word[i];
      hold(4);
      ser_clk_o  <= 1'b1;
      hold(4);
      ser_clk_o  <= 1'b0;
    end
    ser_data_o    <= ~word[0];  // Released data line shows the inverse
    hold(4);
    load_strobe_o <= 1'b1;
    hold(4);
    load_strobe_o <= 1'b0;
    hold(4);
  endtask : send_word
endmodule : pls_host_model

// [bench/tb_top.sv]
// Self-checking bench of the synthesizer core, judged by monitor periods and pumps
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pls_pkg::*;

  logic        clk_sys = 1'b0;
  logic        nrst    = 1'b0;
  logic        pol     = 1'b1;
  logic        ref_clk = 1'b0;
  logic        vco_clk = 1'b0;
  logic        ser_data;
  logic        ser_clk;
  logic        load_strobe;
  logic        pump_up;
  logic        pump_dn;
  logic        monitor;
  logic        ce      = 1'b1;
  int          up_cnt  = 0;
  int          dn_cnt  = 0;
  logic [31:0] seed    = 32'h5650;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc     = 0;
  int          last_t  = 0;
  int          exp_q[$];

  // ------------------------------------------------------------
  // Clock, stand-in oscillators and design
  // ------------------------------------------------------------
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // Reference and VCO toggle every two cycles, four cycles a period
  always @(posedge clk_sys) begin
    cyc     <= cyc + 1;
    ref_clk <= cyc[1];
    vco_clk <= ~cyc[1];
  end

  pls_host_model host (
    .clk_sys_i     (clk_sys),
    .ser_data_o    (ser_data),
    .ser_clk_o     (ser_clk),
    .load_strobe_o (load_strobe)
  );

  pls_synth_core dut (
    .clk_sys_i         (clk_sys),
    .nrst_i            (nrst),
    .ce_i              (ce),
    .ser_data_i        (ser_data),
    .ser_clk_i         (ser_clk),
    .load_strobe_i     (load_strobe),
    .polarity_select_i (pol),
    .ref_clk_i         (ref_clk),
    .vco_clk_i         (vco_clk),
    .pump_up_o         (pump_up),
    .pump_dn_o         (pump_dn),
    .monitor_o         (monitor)
  );

  // ------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic check(input int got, input int exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: monitor period %0d, expected %0d", $time, got, exp);
    end
  endtask : check

  // Watcher: each monitor pulse closes one period against the oldest note
  always @(posedge clk_sys) begin
    if (pump_up === 1'b1) up_cnt <= up_cnt + 1;
    if (pump_dn === 1'b1) dn_cnt <= dn_cnt + 1;
    if (monitor === 1'b1) begin
      if (exp_q.size() > 0) check(cyc - last_t, exp_q.pop_front());
      last_t <= cyc;
    end
  end

  // Skip two settling pulses, note n periods, wait until all are taken
  task automatic expect_period(input int per, input int n);
    int w;
    w = 0;
    repeat (2) begin
      @(posedge clk_sys);
      while (monitor !== 1'b1 && w < 20000) begin
        @(posedge clk_sys);
        w++;
      end
    end
    #1;
    repeat (n) exp_q.push_back(per);
    w = 0;
    while (exp_q.size() > 0 && w < 40000) begin
      @(posedge clk_sys);
      w++;
    end
    if (exp_q.size() > 0) begin
      error_cnt++;
      $display("wrong value at %0t: monitor pulses missing", $time);
      exp_q.delete();
    end
  endtask : expect_period

  // Pump that carries the leading reference must be active more often than the other
  task automatic flag_check(input int more, input int less);
    samples_checked++;
    if (more <= less) begin
      error_cnt++;
      $display("wrong value at %0t: pump sense, %0d active cycles against %0d", $time, more, less);
    end
  endtask : flag_check

  task automatic stop_test;
    $display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // Watchdog sized well above the expected run
  initial begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [13:0] r;
    logic [6:0]  a;
    int          u0;
    int          d0;
    logic [2:0]  held;
    seed = xs(seed);
    r = 14'h0014 + 14'(seed[2:0]);
    a = 7'(seed[4:3]);
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    expect_period(12, 2);
    flag_check(up_cnt, dn_cnt);
    // Clock enable low must freeze every output
    ce <= 1'b0;
    @(posedge clk_sys);
    held = {pump_up, pump_dn, monitor};
    repeat (5) @(posedge clk_sys);
    samples_checked++;
    if ({pump_up, pump_dn, monitor} !== held) begin
      error_cnt++;
      $display("wrong value at %0t: outputs moved while clock enable was low", $time);
    end
    ce <= 1'b1;
    host.send_word(host.ref_word(r, 1'b1), 19);
    expect_period(4 * int'(r), 2);
    host.send_word(host.ref_word(r + 14'h0005, 1'b1), 18);
    expect_period(4 * int'(r), 2);
    host.send_word(host.main_word(11'h003, a), 19);
    pol <= 1'b0;
    u0 = up_cnt;
    d0 = dn_cnt;
    expect_period(4 * (64 * 3 + int'(a)), 2);
    host.send_word(host.ref_word(r, 1'b0), 19);
    expect_period(4 * (128 * 3 + int'(a)), 2);
    host.send_word(host.main_word(11'h007, 7'h07), 19);
    expect_period(4 * (128 * 7 + 7), 2);
    flag_check(dn_cnt - d0, up_cnt - u0);
    stop_test();
  end
endmodule : tb_top
